// ==== design/bank1_regs_pkg.sv ====
// Constants, types and register layout for the bank-one special register block
//
// How it works
// - Unmapped addresses and unimplemented bits read zero; writes to them do nothing.
// - Upper program counter bits load only from the latch when counter loads.
// - Shared core registers answer at their offset in every bank, one copy.
// - Without forty-pin option, port D/E direction locations read zero, ignore writes.
// - Pin or watchdog reset loads other-reset values, keeps unchanged bits, records cause.
// - Port A direction has six bits, all one after every reset.
package bank1_regs_pkg;

  // Bus geometry: register index is the word address
  localparam int ADDR_W  = 11;
  localparam int INDEX_W = ADDR_W - 2;
  localparam int REG_COUNT = 18;
  localparam logic [1:0] RESP_OKAY = 2'h0;

  // Register indices as printed
  localparam logic [8:0] IDX_INDIRECT_DATA = 9'h080;
  localparam logic [8:0] IDX_TIMER0_CFG    = 9'h081;
  localparam logic [8:0] IDX_PC_LOW        = 9'h082;
  localparam logic [8:0] IDX_CORE_FLAGS    = 9'h083;
  localparam logic [8:0] IDX_POINTER       = 9'h084;
  localparam logic [8:0] IDX_PORT_A_DIR    = 9'h085;
  localparam logic [8:0] IDX_PORT_B_DIR    = 9'h086;
  localparam logic [8:0] IDX_PORT_C_DIR    = 9'h087;
  localparam logic [8:0] IDX_PORT_D_DIR    = 9'h088;
  localparam logic [8:0] IDX_PORT_E_DIR    = 9'h089;
  localparam logic [8:0] IDX_PC_LATCH      = 9'h08A;
  localparam logic [8:0] IDX_IRQ_CONTROL   = 9'h08B;
  localparam logic [8:0] IDX_PERIPH_IE1    = 9'h08C;
  localparam logic [8:0] IDX_PERIPH_IE2    = 9'h08D;
  localparam logic [8:0] IDX_POWER_CAUSE   = 9'h08E;
  localparam logic [8:0] IDX_SSP_CTRL2     = 9'h091;
  localparam logic [8:0] IDX_T2_PERIOD     = 9'h092;
  localparam logic [8:0] IDX_SSP_ADDR      = 9'h093;
  localparam logic [8:0] IDX_SSP_STATE     = 9'h094;
  localparam logic [8:0] IDX_TX_CTRL       = 9'h098;
  localparam logic [8:0] IDX_BAUD_DIV      = 9'h099;
  localparam logic [8:0] IDX_ADC_RES_LOW   = 9'h09E;
  localparam logic [8:0] IDX_ADC_CFG2      = 9'h09F;

  // Slot numbers of the plain storage registers
  localparam int SLOT_POINTER   = 1;
  localparam int SLOT_PORT_E    = 6;
  localparam int SLOT_PC_LATCH  = 7;
  localparam int SLOT_SSP_STATE = 14;
  localparam int SLOT_TX_CTRL   = 15;

  // Slot tables, slot 17 first
  localparam logic [REG_COUNT-1:0][8:0] SLOT_INDEX = {
    IDX_ADC_CFG2, IDX_BAUD_DIV, IDX_TX_CTRL, IDX_SSP_STATE, IDX_SSP_ADDR, IDX_T2_PERIOD,
    IDX_SSP_CTRL2, IDX_PERIPH_IE2, IDX_PERIPH_IE1, IDX_IRQ_CONTROL, IDX_PC_LATCH,
    IDX_PORT_E_DIR, IDX_PORT_D_DIR, IDX_PORT_C_DIR, IDX_PORT_B_DIR, IDX_PORT_A_DIR,
    IDX_POINTER, IDX_TIMER0_CFG};
  localparam logic [REG_COUNT-1:0][7:0] SLOT_MASK = {
    8'h8F, 8'hFF, 8'hF5, 8'hC0, 8'hFF, 8'hFF, 8'hFF, 8'h19, 8'hFF, 8'hFF, 8'h1F,
    8'h17, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'hFF, 8'hFF};
  localparam logic [REG_COUNT-1:0][7:0] SLOT_POR = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h3F, 8'h00, 8'hFF};
  localparam logic [REG_COUNT-1:0][7:0] SLOT_KEEP = {
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};
  localparam logic [REG_COUNT-1:0] SLOT_MIRROR = 18'h0_0182;
  localparam logic [REG_COUNT-1:0] SLOT_FORTY  = 18'h0_0060;

  // Core flags and power-cause layout
  localparam logic [7:0]  FLAGS_POR      = 8'h18;
  localparam logic [7:0]  FLAGS_WR_MASK  = 8'hE7;
  localparam int          FLAGS_TO_BIT   = 4;
  localparam int          FLAGS_PD_BIT   = 3;
  localparam int          FLAGS_IRP_BIT  = 7;
  localparam logic [1:0]  CAUSE_POR      = 2'h1;
  localparam int          CAUSE_BOR_BIT  = 0;
  localparam logic [12:0] PC_RESET       = 13'h0000;
  localparam int          OVERFLOW_BIT   = 5;

  // Types
  typedef logic [REG_COUNT-1:0][7:0] slot_values_t;

  typedef struct packed {
    logic       we;
    logic [8:0] addr;
    logic [7:0] wdata;
  } dmem_cmd_t;

  typedef struct packed {
    logic [12:0] pc;
    logic [7:0]  core_flags;
    logic [1:0]  power_cause;
  } core_view_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_MEM   = 4'b0010,
    ST_BRESP = 4'b0100,
    ST_RRESP = 4'b1000
  } bus_state_t;

endpackage

// ==== design/bank_reg.sv ====
// One masked storage register with power-up and other-reset values
`timescale 1ns/1ps
`default_nettype none
module bank_reg #(
  parameter logic [7:0] MASK      = 8'hFF,
  parameter logic [7:0] POR_VALUE = 8'h00,
  parameter logic [7:0] KEEP      = 8'h00
) (
  // Clock and resets
  input  wire logic       aclk,
  input  wire logic       power_rst,
  input  wire logic       other_rst,
  // Write port
  input  wire logic       write_en,
  input  wire logic [7:0] write_data,
  // Stored value
  output logic      [7:0] value_reg
);

  // Bits outside the mask never hold a one
  always_ff @(posedge aclk) begin
    if (power_rst) begin
      value_reg <= POR_VALUE & MASK;
    end else if (other_rst) begin
      value_reg <= ((POR_VALUE & ~KEEP) | (value_reg & KEEP)) & MASK;
    end else if (write_en) begin
      value_reg <= write_data & MASK;
    end
  end

endmodule
`default_nettype wire

// ==== design/program_counter_unit.sv ====
// Program counter with latch-fed upper bits
`timescale 1ns/1ps
`default_nettype none
module program_counter_unit (
  // Clock and resets
  input  wire logic        aclk,
  input  wire logic        power_rst,
  input  wire logic        other_rst,
  // Load and step
  input  wire logic        low_write,
  input  wire logic [7:0]  low_data,
  input  wire logic [4:0]  upper_latch,
  input  wire logic        step,
  // Counter
  output logic      [12:0] pc_reg
);
  import bank1_regs_pkg::*;

  // Upper bits have no write path of their own
  always_ff @(posedge aclk) begin
    if (power_rst || other_rst) begin
      pc_reg <= PC_RESET;
    end else if (low_write) begin
      pc_reg <= {upper_latch, low_data};
    end else if (step) begin
      pc_reg <= pc_reg + 13'h0001;
    end
  end

endmodule
`default_nettype wire

// ==== design/bank1_special_registers.sv ====
// Bank-one special register file behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module bank1_special_registers #(
  parameter logic FORTY_PIN = 1'b1
) (
  // Clock and bus reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address
  input  wire logic [bank1_regs_pkg::ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]                           awprot,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  // AXI4-Lite write data
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  // AXI4-Lite write response
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  // AXI4-Lite read address
  input  wire logic [bank1_regs_pkg::ADDR_W-1:0]    araddr,
  input  wire logic [2:0]                           arprot,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  // AXI4-Lite read data
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  // Reset causes
  input  wire logic                                 brownout_reset,
  input  wire logic                                 other_reset,
  input  wire logic                                 timeout_cause,
  input  wire logic                                 powerdown_cause,
  // Core and peripheral status
  input  wire logic                                 pc_step,
  input  wire logic                                 slave_port_in_full,
  input  wire logic                                 slave_port_out_full,
  input  wire logic                                 slave_port_overflow,
  input  wire logic [5:0]                           ssp_status,
  input  wire logic                                 transmit_empty,
  input  wire logic [7:0]                           converter_result_low,
  // Data memory port for indirect access
  output bank1_regs_pkg::dmem_cmd_t                 dmem_cmd,
  output logic                                      dmem_valid,
  input  wire logic                                 dmem_ack,
  input  wire logic [7:0]                           dmem_rdata,
  // Register contents to the peripherals and core
  output bank1_regs_pkg::slot_values_t              slot_values,
  output bank1_regs_pkg::core_view_t                core_view
);
  import bank1_regs_pkg::*;

  // Bus bookkeeping
  bus_state_t         state_reg;
  logic               awready_reg;
  logic               wready_reg;
  logic               arready_reg;
  logic               aw_held_reg;
  logic               w_held_reg;
  logic               ar_held_reg;
  logic [INDEX_W-1:0] wr_index_reg;
  logic [INDEX_W-1:0] rd_index_reg;
  logic [7:0]         wr_data_reg;
  logic               wr_lane_reg;
  logic               mem_read_reg;
  logic               bvalid_reg;
  logic               rvalid_reg;
  logic [31:0]        rdata_reg;
  dmem_cmd_t          dmem_cmd_reg;
  logic               dmem_valid_reg;

  // Special registers
  logic [7:0]         flags_reg;
  logic [1:0]         cause_reg;
  logic               overflow_reg;
  logic [12:0]        pc_value;
  slot_values_t       slot_q;
  slot_values_t       slot_extra;

  // Decode and handshakes
  logic                 power_rst;
  logic                 other_rst;
  logic                 aw_take;
  logic                 w_take;
  logic                 ar_take;
  logic                 write_go;
  logic                 read_go;
  logic                 aw_held_next;
  logic                 w_held_next;
  logic                 ar_held_next;
  logic [REG_COUNT-1:0] wr_hit;
  logic [REG_COUNT-1:0] rd_hit;
  logic                 wr_indirect;
  logic                 rd_indirect;
  logic                 pointer_self;
  logic                 reg_write;
  logic [7:0]           read_value;

  // Brown-out acts like power-up; the bus itself only follows aresetn
  assign power_rst = !aresetn || brownout_reset;
  assign other_rst = other_reset && !power_rst;

  // Handshake terms
  assign aw_take  = awvalid && awready_reg;
  assign w_take   = wvalid && wready_reg;
  assign ar_take  = arvalid && arready_reg;
  assign write_go = (state_reg == ST_IDLE) && aw_held_reg && w_held_reg;
  assign read_go  = (state_reg == ST_IDLE) && ar_held_reg && !write_go;

  assign aw_held_next = write_go ? 1'b0 : (aw_held_reg || aw_take);
  assign w_held_next  = write_go ? 1'b0 : (w_held_reg || w_take);
  assign ar_held_next = read_go ? 1'b0 : (ar_held_reg || ar_take);

  // Shared core registers match in any bank, the rest only in bank one
  function automatic logic slot_match(input logic [INDEX_W-1:0] idx, input int g);
    logic hit;
    hit = 1'b0;
    if (SLOT_MIRROR[g]) begin
      hit = (idx[6:0] == SLOT_INDEX[g][6:0]);
    end else begin
      hit = (idx == SLOT_INDEX[g]);
    end
    if (SLOT_FORTY[g] && !FORTY_PIN) begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // Slot hit vectors for both directions
  always_comb begin
    wr_hit = '0;
    rd_hit = '0;
    for (int g = 0; g < REG_COUNT; g++) begin
      wr_hit[g] = slot_match(wr_index_reg, g);
      rd_hit[g] = slot_match(rd_index_reg, g);
    end
  end

  // Indirect port holds nothing; pointing it at itself reads zero
  assign wr_indirect  = (wr_index_reg[6:0] == IDX_INDIRECT_DATA[6:0]);
  assign rd_indirect  = (rd_index_reg[6:0] == IDX_INDIRECT_DATA[6:0]);
  assign pointer_self = (slot_q[SLOT_POINTER][6:0] == IDX_INDIRECT_DATA[6:0]);

  // Only byte lane zero carries register data
  assign reg_write = write_go && wr_lane_reg && !wr_indirect;

  // Write channel capture, one address and one data word held at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      wr_index_reg <= '0;
      wr_data_reg  <= 8'h00;
      wr_lane_reg  <= 1'b0;
    end else begin
      aw_held_reg <= aw_held_next;
      w_held_reg  <= w_held_next;
      awready_reg <= !aw_held_next;
      wready_reg  <= !w_held_next;
      if (aw_take) begin
        wr_index_reg <= awaddr[ADDR_W-1:2];
      end
      if (w_take) begin
        wr_data_reg <= wdata[7:0];
        wr_lane_reg <= wstrb[0];
      end
    end
  end

  // Read address capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ar_held_reg  <= 1'b0;
      arready_reg  <= 1'b0;
      rd_index_reg <= '0;
    end else begin
      ar_held_reg <= ar_held_next;
      arready_reg <= !ar_held_next;
      if (ar_take) begin
        rd_index_reg <= araddr[ADDR_W-1:2];
      end
    end
  end

  // Status bits merged from the peripherals into their slots
  always_comb begin
    slot_extra = '0;
    if (FORTY_PIN) begin
      slot_extra[SLOT_PORT_E] = {slave_port_in_full, slave_port_out_full, overflow_reg, 5'h00};
    end
    slot_extra[SLOT_SSP_STATE] = {2'h0, ssp_status};
    slot_extra[SLOT_TX_CTRL]   = {6'h00, transmit_empty, 1'b0};
  end

  // Read multiplexer; anything not matched stays zero
  always_comb begin
    read_value = 8'h00;
    for (int g = 0; g < REG_COUNT; g++) begin
      if (rd_hit[g]) begin
        read_value = slot_q[g] | slot_extra[g];
      end
    end
    if (rd_index_reg[6:0] == IDX_PC_LOW[6:0]) begin
      read_value = pc_value[7:0];
    end
    if (rd_index_reg[6:0] == IDX_CORE_FLAGS[6:0]) begin
      read_value = flags_reg;
    end
    if (rd_index_reg == IDX_POWER_CAUSE) begin
      read_value = {6'h00, cause_reg};
    end
    if (rd_index_reg == IDX_ADC_RES_LOW) begin
      read_value = converter_result_low;
    end
  end

  // Transaction sequencer: writes win a tie, one access in flight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg    <= ST_IDLE;
      bvalid_reg   <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      mem_read_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (write_go) begin
            if (wr_indirect && wr_lane_reg && !pointer_self) begin
              mem_read_reg <= 1'b0;
              state_reg    <= ST_MEM;
            end else begin
              bvalid_reg <= 1'b1;
              state_reg  <= ST_BRESP;
            end
          end else if (read_go) begin
            if (rd_indirect && !pointer_self) begin
              mem_read_reg <= 1'b1;
              state_reg    <= ST_MEM;
            end else begin
              rdata_reg  <= {24'h00_0000, read_value};
              rvalid_reg <= 1'b1;
              state_reg  <= ST_RRESP;
            end
          end
        end
        ST_MEM: begin
          if (dmem_ack) begin
            if (mem_read_reg) begin
              rdata_reg  <= {24'h00_0000, dmem_rdata};
              rvalid_reg <= 1'b1;
              state_reg  <= ST_RRESP;
            end else begin
              bvalid_reg <= 1'b1;
              state_reg  <= ST_BRESP;
            end
          end
        end
        ST_BRESP: begin
          if (bready) begin
            bvalid_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        ST_RRESP: begin
          if (rready) begin
            rvalid_reg <= 1'b0;
            state_reg  <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Data memory request; address is the bank bit plus the pointer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dmem_valid_reg <= 1'b0;
      dmem_cmd_reg   <= '0;
    end else if (state_reg == ST_IDLE && write_go && wr_indirect && wr_lane_reg
                 && !pointer_self) begin
      dmem_valid_reg <= 1'b1;
      dmem_cmd_reg   <= '{we: 1'b1, addr: {flags_reg[FLAGS_IRP_BIT], slot_q[SLOT_POINTER]},
                          wdata: wr_data_reg};
    end else if (state_reg == ST_IDLE && read_go && rd_indirect && !pointer_self) begin
      dmem_valid_reg <= 1'b1;
      dmem_cmd_reg   <= '{we: 1'b0, addr: {flags_reg[FLAGS_IRP_BIT], slot_q[SLOT_POINTER]},
                          wdata: 8'h00};
    end else if (state_reg == ST_MEM && dmem_ack) begin
      dmem_valid_reg <= 1'b0;
    end
  end

  // Plain storage registers, one instance per slot
  for (genvar g = 0; g < REG_COUNT; g++) begin : gen_slot
    bank_reg #(
      .MASK      (SLOT_MASK[g]),
      .POR_VALUE (SLOT_POR[g]),
      .KEEP      (SLOT_KEEP[g])
    ) u_slot (
      .aclk       (aclk),
      .power_rst  (power_rst),
      .other_rst  (other_rst),
      .write_en   (reg_write && wr_hit[g]),
      .write_data (wr_data_reg),
      .value_reg  (slot_q[g])
    );
  end

  // Program counter, low byte written through the bus
  program_counter_unit u_pc (
    .aclk        (aclk),
    .power_rst   (power_rst),
    .other_rst   (other_rst),
    .low_write   (reg_write && (wr_index_reg[6:0] == IDX_PC_LOW[6:0])),
    .low_data    (wr_data_reg),
    .upper_latch (slot_q[SLOT_PC_LATCH][4:0]),
    .step        (pc_step),
    .pc_reg      (pc_value)
  );

  // Core flags; timeout and power-down bits are read-only for software
  always_ff @(posedge aclk) begin
    if (power_rst) begin
      flags_reg <= FLAGS_POR;
    end else if (other_rst) begin
      flags_reg                <= {3'h0, 2'h0, flags_reg[2:0]};
      flags_reg[FLAGS_TO_BIT]  <= timeout_cause;
      flags_reg[FLAGS_PD_BIT]  <= powerdown_cause;
    end else if (reg_write && (wr_index_reg[6:0] == IDX_CORE_FLAGS[6:0])) begin
      flags_reg <= (wr_data_reg & FLAGS_WR_MASK) | (flags_reg & ~FLAGS_WR_MASK);
    end
  end

  // Power-cause bits; hardware clears, software sets them back
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cause_reg <= CAUSE_POR;
    end else if (brownout_reset) begin
      cause_reg[CAUSE_BOR_BIT] <= 1'b0;
    end else if (other_rst) begin
      cause_reg <= cause_reg;
    end else if (reg_write && (wr_index_reg == IDX_POWER_CAUSE)) begin
      cause_reg <= wr_data_reg[1:0];
    end
  end

  // Slave-port overflow: sticky, set wins over a software clear
  always_ff @(posedge aclk) begin
    if (power_rst || other_rst || !FORTY_PIN) begin
      overflow_reg <= 1'b0;
    end else if (slave_port_overflow) begin
      overflow_reg <= 1'b1;
    end else if (reg_write && wr_hit[SLOT_PORT_E] && !wr_data_reg[OVERFLOW_BIT]) begin
      overflow_reg <= 1'b0;
    end
  end

  // Output drive, all from flip-flops except the constant bresp and rresp
  assign awready     = awready_reg;
  assign wready      = wready_reg;
  assign arready     = arready_reg;
  assign bvalid      = bvalid_reg;
  assign bresp       = RESP_OKAY;
  assign rvalid      = rvalid_reg;
  assign rresp       = RESP_OKAY;
  assign rdata       = rdata_reg;
  assign dmem_valid  = dmem_valid_reg;
  assign dmem_cmd    = dmem_cmd_reg;
  assign slot_values = slot_q;
  assign core_view   = '{pc: pc_value, core_flags: flags_reg, power_cause: cause_reg};

endmodule
`default_nettype wire

// ==== tb/bank1_regs_sva.sv ====
// Concurrent checks on the ports of the bank-one special register block
`timescale 1ns/1ps
`default_nettype none
module bank1_regs_sva (
  // Clock and reset
  input wire logic                         aclk,
  input wire logic                         aresetn,
  // Bus handshakes
  input wire logic                         awvalid,
  input wire logic                         awready,
  input wire logic                         wvalid,
  input wire logic                         wready,
  input wire logic                         bvalid,
  input wire logic [1:0]                   bresp,
  input wire logic                         arvalid,
  input wire logic                         arready,
  input wire logic                         rvalid,
  input wire logic [1:0]                   rresp,
  input wire logic [31:0]                  rdata,
  // Resets and memory port
  input wire logic                         brownout_reset,
  input wire logic                         other_reset,
  input wire bank1_regs_pkg::dmem_cmd_t    dmem_cmd,
  input wire logic                         dmem_valid,
  input wire logic                         dmem_ack,
  // Register contents
  input wire bank1_regs_pkg::slot_values_t slot_values,
  input wire bank1_regs_pkg::core_view_t   core_view
);
  import bank1_regs_pkg::*;
  // Single domain, bus reset masks everything
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_BRESP_OKAY:
    assert property (bvalid |-> bresp == 2'h0) else $error("bresp");
  AST_RDATA_UPPER:
    assert property (rvalid |-> rdata[31:8] == 24'h00_0000 && rresp == 2'h0)
      else $error("read upper");
  AST_WRITE_ANSWER:
    assert property (awvalid && awready && wvalid && wready |-> ##[1:2] (bvalid || dmem_valid))
      else $error("no bvalid");
  AST_READ_ANSWER:
    assert property (arvalid && arready |-> ##[1:40] rvalid) else $error("no rvalid");
  AST_DMEM_HOLD:
    assert property (dmem_valid && !dmem_ack |=> dmem_valid && $stable(dmem_cmd))
      else $error("dmem drop");
  AST_PORT_A_BITS:
    assert property (slot_values[2][7:6] == 2'h0) else $error("port A bits");
  AST_IE2_RESERVED:
    assert property ((slot_values[10] & 8'hE6) == 8'h00) else $error("ie2 hole set");
  AST_POWER_UP:
    assert property ($rose(aresetn) |-> slot_values[2] == 8'h3F && slot_values[12] == 8'hFF
      && core_view.pc == 13'h0000) else $error("power-up values");
  AST_BROWNOUT:
    assert property (brownout_reset |=> slot_values[12] == 8'hFF && slot_values[0] == 8'hFF)
      else $error("brownout values");
  AST_OTHER_RESET:
    assert property (other_reset && !brownout_reset |=> slot_values[2] == 8'h3F
      && slot_values[1] == $past(slot_values[1])) else $error("other reset values");
endmodule
bind bank1_special_registers bank1_regs_sva chk_u (.aclk, .aresetn, .awvalid, .awready, .wvalid,
  .wready, .bvalid, .bresp, .arvalid, .arready, .rvalid, .rresp, .rdata, .brownout_reset,
  .other_reset, .dmem_cmd, .dmem_valid, .dmem_ack, .slot_values, .core_view);
`default_nettype wire

// ==== tb/tb.sv ====
// Register-level bench for the bank-one special register block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import bank1_regs_pkg::*;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dmem_ack;
  logic              awready, wready, bvalid, arready, rvalid, dmem_valid, pc_step;
  logic              brownout_reset, other_reset, timeout_cause, powerdown_cause;
  logic              slave_port_in_full, slave_port_out_full, slave_port_overflow;
  logic              transmit_empty;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp;
  logic [5:0]        ssp_status;
  logic [7:0]        dmem_rdata, converter_result_low;
  dmem_cmd_t         dmem_cmd, dm_seen;
  slot_values_t      slot_values;
  core_view_t        core_view;
  int                err_count, check_count;
  // Clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  bank1_special_registers #(.FORTY_PIN(1'b1)) dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0),
    .awvalid, .awready, .wdata, .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .brownout_reset, .other_reset, .timeout_cause, .powerdown_cause, .pc_step,
    .slave_port_in_full, .slave_port_out_full, .slave_port_overflow, .ssp_status,
    .transmit_empty, .converter_result_low, .dmem_cmd, .dmem_valid, .dmem_ack, .dmem_rdata,
    .slot_values, .core_view);
  // Data memory answers a cycle late; data is the address plus a constant
  always @(posedge aclk) begin
    dmem_ack <= dmem_valid && !dmem_ack;
    dmem_rdata <= dmem_cmd.addr[7:0] + 8'h11;
    if (dmem_valid && dmem_ack) dm_seen <= dmem_cmd;
  end
  task automatic check(input logic [17:0] s, input logic [17:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [8:0] i, input logic [7:0] d);
    logic ok;
    ok = 1'b0;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= {24'h00_0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      ok = (bvalid === 1'b1);
    end
    bready <= 1'b0;
    if (!ok) begin
      err_count++;
      test_done;
    end
  endtask
  task automatic rd(input logic [8:0] i, output logic [7:0] r);
    logic ok;
    ok = 1'b0;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++) begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      ok = (rvalid === 1'b1);
      r = rdata[7:0];
    end
    rready <= 1'b0;
    if (!ok) begin
      err_count++;
      test_done;
    end
  endtask
  // Optional write, then read back and compare
  task automatic acc(input logic [8:0] i, input logic w, input logic [7:0] d, input logic [7:0] e);
    logic [7:0] r;
    if (w) wr(i, d);
    rd(i, r);
    check({10'h000, r}, {10'h000, e});
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, pc_step} = 7'h00;
    {brownout_reset, other_reset, timeout_cause, powerdown_cause} = 4'h0;
    {slave_port_in_full, slave_port_out_full, slave_port_overflow, transmit_empty} = 4'h0;
    {awaddr, araddr, wdata, ssp_status, converter_result_low} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    acc(9'h081, 0, 8'h00, 8'hFF);
    acc(9'h083, 0, 8'h00, 8'h18);
    acc(9'h085, 0, 8'h00, 8'h3F);
    acc(9'h088, 0, 8'h00, 8'hFF);
    acc(9'h089, 0, 8'h00, 8'h07);
    acc(9'h08E, 0, 8'h00, 8'h01);
    acc(9'h092, 0, 8'h00, 8'hFF);
    $display("reset values done");
    acc(9'h085, 1, 8'hFF, 8'h3F);
    acc(9'h08D, 1, 8'hBF, 8'h19);
    acc(9'h08C, 1, 8'h7F, 8'h7F);
    acc(9'h09F, 1, 8'hFF, 8'h8F);
    acc(9'h08F, 1, 8'hFF, 8'h00);
    acc(9'h09C, 1, 8'hFF, 8'h00);
    acc(9'h094, 1, 8'hFF, 8'hC0);
    $display("masks and holes done");
    acc(9'h004, 1, 8'h5A, 8'h5A);
    acc(9'h184, 0, 8'h00, 8'h5A);
    acc(9'h10A, 1, 8'h03, 8'h03);
    wr(9'h182, 8'h34);
    check({5'h00, core_view.pc}, 18'h0_0334);
    pc_step <= 1'b1;
    @(posedge aclk);
    pc_step <= 1'b0;
    acc(9'h082, 0, 8'h00, 8'h35);
    check({5'h00, core_view.pc}, 18'h0_0335);
    $display("mirrors and counter done");
    wr(9'h080, 8'hC3);
    check(dm_seen, {1'b1, 9'h05A, 8'hC3});
    acc(9'h180, 0, 8'h00, 8'h6B);
    $display("indirect done");
    {slave_port_in_full, slave_port_out_full, slave_port_overflow, transmit_empty} <= 4'hF;
    ssp_status <= 6'h2A;
    converter_result_low <= 8'h9C;
    @(posedge aclk);
    slave_port_overflow <= 1'b0;
    acc(9'h089, 0, 8'h00, 8'hE7);
    acc(9'h094, 0, 8'h00, 8'hEA);
    acc(9'h098, 0, 8'h00, 8'h02);
    acc(9'h09E, 0, 8'h00, 8'h9C);
    acc(9'h089, 1, 8'h07, 8'hC7);
    $display("live status done");
    acc(9'h085, 1, 8'h00, 8'h00);
    acc(9'h08B, 1, 8'hFF, 8'hFF);
    timeout_cause <= 1'b1;
    other_reset <= 1'b1;
    @(posedge aclk);
    {other_reset, timeout_cause} <= 2'h0;
    acc(9'h085, 0, 8'h00, 8'h3F);
    acc(9'h084, 0, 8'h00, 8'h5A);
    acc(9'h083, 0, 8'h00, 8'h10);
    acc(9'h08B, 0, 8'h00, 8'h01);
    acc(9'h08E, 0, 8'h00, 8'h01);
    $display("other reset done");
    acc(9'h092, 1, 8'h12, 8'h12);
    brownout_reset <= 1'b1;
    @(posedge aclk);
    brownout_reset <= 1'b0;
    acc(9'h092, 0, 8'h00, 8'hFF);
    acc(9'h084, 0, 8'h00, 8'h00);
    acc(9'h08E, 0, 8'h00, 8'h00);
    $display("brownout done");
    test_done;
  end
endmodule
`default_nettype wire
